// ===== logic/osc_refclk_pkg.sv
`default_nettype none
package osc_refclk_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_OSC_CTRL = 10'h100;
    localparam logic [9:0] IDX_CLOCK_DIVIDER_CONTROL = 10'h102;
    localparam logic [9:0] IDX_FRC_TUNE = 10'h106;
    localparam logic [9:0] IDX_SYSTEM_OSC_DIVISOR = 10'h10c;
    localparam logic [9:0] IDX_SYSTEM_OSC_FRACTIONAL_DIVISOR = 10'h10e;
    localparam logic [9:0] IDX_REF_LO = 10'h168;
    localparam logic [9:0] IDX_REF_HI = 10'h16a;
    localparam logic [9:0] IDX_UNLOCK = 10'h170;
    localparam logic [11:0] A_OSC_CTRL = {IDX_OSC_CTRL, 2'b00};
    localparam logic [11:0] A_CLOCK_DIVIDER_CONTROL = {IDX_CLOCK_DIVIDER_CONTROL, 2'b00};
    localparam logic [11:0] A_FRC_TUNE = {IDX_FRC_TUNE, 2'b00};
    localparam logic [11:0] A_SYSTEM_OSC_DIVISOR = {IDX_SYSTEM_OSC_DIVISOR, 2'b00};
    localparam logic [11:0] A_SYSTEM_OSC_FRACTIONAL_DIVISOR = {IDX_SYSTEM_OSC_FRACTIONAL_DIVISOR, 2'b00};
    localparam logic [11:0] A_REF_LO = {IDX_REF_LO, 2'b00};
    localparam logic [11:0] A_REF_HI = {IDX_REF_HI, 2'b00};
    localparam logic [11:0] A_UNLOCK = {IDX_UNLOCK, 2'b00};
    // unlock keys, arbitrary values
    localparam logic [15:0] UNLOCK_KEY1 = 16'h0046;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h0057;
    localparam logic [15:0] CLOCK_DIVIDER_CONTROL_RST = 16'h3020;
    localparam logic [15:0] CLOCK_DIVIDER_CONTROL_MASK = 16'hffe0;
    localparam logic [15:0] SYSTEM_OSC_DIVISOR_MASK = 16'h7fff;
    localparam logic [15:0] SYSTEM_OSC_FRACTIONAL_DIVISOR_MASK = 16'h7f80;
    localparam logic [1:0] FSM_ON = 2'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [3:0] RSEL_PLL_VCO = 4'h6;
    localparam logic [3:0] RSEL_REF_PIN = 4'h8;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_ONE = 2'b01,
        KEY_OPEN = 2'b10
    } key_e;

    typedef struct packed {
        logic [7:0] src_m;
        logic [7:0] src_s;
        logic src_prev;
        logic pll_m;
        logic pll_s;
        logic started;
        key_e key_st;
        logic [2:0] cur_src;
        logic [2:0] req_src;
        logic sw_req;
        logic clk_frz;
        logic pin_frz;
        logic pll_ok;
        logic cf;
        logic primary_osc_keep;
        logic secondary_osc_en;
        logic [15:0] clock_divider_control;
        logic [15:0] system_osc_divisor;
        logic [15:0] system_osc_fractional_divisor;
        logic st_en;
        logic st_idl;
        logic st_src;
        logic st_lpol;
        logic st_orpol;
        logic [5:0] trim;
        logic ro_en;
        logic ro_idl;
        logic ro_out;
        logic ro_slp;
        logic ro_swreq;
        logic ro_act;
        logic [3:0] ro_sel;
        logic [14:0] ro_div;
        logic [14:0] div_eff;
        logic [14:0] cnt;
        logic ro_clk;
        logic [15:0] rdata;
    } osc_state_s;
endpackage
`default_nettype wire

// ===== logic/osc_refclk_ctrl.sv
`default_nettype none
// Functional notes
// R1: enable bit starts and stops reference clock
// R2: 15-bit half-period divider sets output rate
// R3: divider change via request bit, hardware clears
// R4: 4-bit field picks reference clock source
// R5: run-in-sleep keeps reference clock during sleep
// R6: pin drive bit gates pin, independent of enable
// R7: active status clears after module disabled
// R8: software leaves source/divider alone while active
// R9: pll may feed reference clock independently
// R10: oscillator control writes need unlock sequence
// R11: one 3-bit encoding for current/requested source
// R12: switch request starts system clock switch
// R13: freeze locks selections only with monitor on
// R14: pin map freeze needs unlock, one-way option
// R15: pll settled clears on switch or non-pll mode
// R16: clock failure sets clock fail flag
// R17: primary oscillator sleep keep bit
// R18: secondary oscillator enable bit
// R19: self-tune owns trim, trim read-only then
// R20: self-tune reference and idle-stop bits
// R21: in-range status with interrupt polarity
// R22: out-of-range status stops tuning, polarity
// R23: reference source code map, others reserved
// R24: output is source over twice divider, zero bypass
// R25: switch request reads zero when switch done
// R26: disabled output holds low, no partial pulses
module osc_refclk_ctrl
    import osc_refclk_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [11:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [7:0] i_ref_src,
    input wire logic i_pll_locked,
    input wire logic [2:0] i_reset_clock_source,
    input wire logic [1:0] i_fail_safe_monitor_config,
    input wire logic i_pin_map_freeze_once_config,
    input wire logic i_pll_source_select_config,
    input wire logic i_switch_done,
    input wire logic i_clock_fail,
    input wire logic i_sleep,
    input wire logic i_idle,
    input wire logic i_selftune_in_range,
    input wire logic i_selftune_out_of_range,
    input wire logic [5:0] i_selftune_trim,
    output logic o_switch_req,
    output logic [2:0] o_requested_clock_source,
    output logic [2:0] o_current_clock_source,
    output logic o_primary_osc_run,
    output logic o_secondary_osc_enable,
    output logic o_pll_input_frc,
    output logic o_pin_map_frozen,
    output logic o_selftune_run,
    output logic o_selftune_ref_select,
    output logic o_selftune_in_range_event,
    output logic o_selftune_out_of_range_event,
    output logic [5:0] o_frc_trim,
    output logic [15:0] o_clock_divider_control_cfg,
    output logic [15:0] o_system_osc_divisor_cfg,
    output logic [15:0] o_system_osc_fractional_divisor_cfg,
    output logic o_refclk,
    output logic o_reference_clock_pin,
    output logic o_reference_clock_pin_oe_n
);
    osc_state_s st_r;
    osc_state_s st_nxt;
    logic wr_osc;
    logic sel_frozen;
    logic run;
    logic src_bit;
    logic tgl;
    logic pll_mode;
    logic in_rng;
    logic oor;
    logic [15:0] rd_val;

    assign wr_osc = i_wr && i_addr == A_OSC_CTRL && st_r.key_st == KEY_OPEN;
    assign sel_frozen = st_r.clk_frz
        && i_fail_safe_monitor_config == FSM_ON; // R13
    assign run = st_r.ro_en && (!i_sleep || st_r.ro_slp) // R1 R5
        && !(i_idle && st_r.ro_idl);
    assign pll_mode = st_r.cur_src == SRC_FRC_PLL
        || st_r.cur_src == SRC_PRI_PLL;
    assign in_rng = st_r.st_en && i_selftune_in_range;
    assign oor = st_r.st_en && i_selftune_out_of_range;

    always_comb begin
        case (st_r.ro_sel) // R4 R23
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, RSEL_PLL_VCO:
                src_bit = st_r.src_s[st_r.ro_sel[2:0]];
            RSEL_REF_PIN: src_bit = st_r.src_s[7];
            default: src_bit = 1'b0;
        endcase
    end

    always_comb begin
        case (i_addr)
            A_OSC_CTRL: rd_val = {1'b0, st_r.cur_src, 1'b0, st_r.req_src,
                st_r.clk_frz, st_r.pin_frz, st_r.pll_ok, 1'b0, st_r.cf,
                st_r.primary_osc_keep, st_r.secondary_osc_en, st_r.sw_req};
            A_CLOCK_DIVIDER_CONTROL: rd_val = st_r.clock_divider_control;
            A_FRC_TUNE: rd_val = {st_r.st_en, 1'b0, st_r.st_idl, st_r.st_src,
                in_rng, st_r.st_lpol, oor, st_r.st_orpol, 2'b00, st_r.trim};
            A_SYSTEM_OSC_DIVISOR: rd_val = st_r.system_osc_divisor;
            A_SYSTEM_OSC_FRACTIONAL_DIVISOR: rd_val = st_r.system_osc_fractional_divisor;
            A_REF_LO: rd_val = {st_r.ro_en, 1'b0, st_r.ro_idl, st_r.ro_out,
                st_r.ro_slp, 1'b0, st_r.ro_swreq, st_r.ro_act, 4'h0,
                st_r.ro_sel};
            A_REF_HI: rd_val = {1'b0, st_r.ro_div};
            default: rd_val = 16'h0000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        tgl = 1'b0;
        st_nxt.src_m = i_ref_src;
        st_nxt.src_s = st_r.src_m;
        st_nxt.src_prev = src_bit;
        st_nxt.pll_m = i_pll_locked;
        st_nxt.pll_s = st_r.pll_m;
        st_nxt.started = 1'b1;
        st_nxt.rdata = i_rd ? rd_val : 16'h0000;
        // strap caught on the first clock after reset release
        if (!st_r.started) begin
            st_nxt.cur_src = i_reset_clock_source;
            st_nxt.req_src = i_reset_clock_source;
        end
        // any write other than the key sequence closes the lock
        if (i_wr) begin
            if (i_addr == A_UNLOCK && i_wdata == UNLOCK_KEY1) begin
                st_nxt.key_st = KEY_ONE;
            end else if (i_addr == A_UNLOCK && i_wdata == UNLOCK_KEY2
                && st_r.key_st == KEY_ONE) begin
                st_nxt.key_st = KEY_OPEN;
            end else begin
                st_nxt.key_st = KEY_IDLE;
            end
        end
        if (wr_osc) begin // R10
            if (!sel_frozen) begin // R13
                st_nxt.req_src = i_wdata[10:8]; // R11
                st_nxt.sw_req = st_r.sw_req | i_wdata[0]; // R12
            end
            st_nxt.clk_frz = st_r.clk_frz | i_wdata[7];
            st_nxt.pin_frz = i_wdata[6]
                | (st_r.pin_frz & i_pin_map_freeze_once_config); // R14
            st_nxt.cf = st_r.cf & i_wdata[3];
            st_nxt.primary_osc_keep = i_wdata[2]; // R17
            st_nxt.secondary_osc_en = i_wdata[1]; // R18
        end
        if (st_r.sw_req && i_switch_done) begin
            st_nxt.cur_src = st_r.req_src;
            st_nxt.sw_req = 1'b0; // R25
        end
        if (i_clock_fail) begin
            st_nxt.cf = 1'b1; // R16
        end
        st_nxt.pll_ok = st_r.pll_s && pll_mode && !st_r.sw_req; // R15
        if (i_wr && i_addr == A_CLOCK_DIVIDER_CONTROL) begin
            st_nxt.clock_divider_control = i_wdata & CLOCK_DIVIDER_CONTROL_MASK;
        end
        if (i_wr && i_addr == A_SYSTEM_OSC_DIVISOR) begin
            st_nxt.system_osc_divisor = i_wdata & SYSTEM_OSC_DIVISOR_MASK;
        end
        if (i_wr && i_addr == A_SYSTEM_OSC_FRACTIONAL_DIVISOR) begin
            st_nxt.system_osc_fractional_divisor = i_wdata & SYSTEM_OSC_FRACTIONAL_DIVISOR_MASK;
        end
        if (i_wr && i_addr == A_FRC_TUNE) begin
            st_nxt.st_en = i_wdata[15];
            st_nxt.st_idl = i_wdata[13]; // R20
            st_nxt.st_src = i_wdata[12]; // R20
            st_nxt.st_lpol = i_wdata[10];
            st_nxt.st_orpol = i_wdata[8];
            if (!st_r.st_en) begin
                st_nxt.trim = i_wdata[5:0];
            end
        end
        if (st_r.st_en) begin
            st_nxt.trim = i_selftune_trim; // R19
        end
        if (i_wr && i_addr == A_REF_LO) begin
            st_nxt.ro_en = i_wdata[15];
            st_nxt.ro_idl = i_wdata[13];
            st_nxt.ro_out = i_wdata[12];
            st_nxt.ro_slp = i_wdata[11];
            st_nxt.ro_swreq = st_r.ro_swreq | i_wdata[9];
            st_nxt.ro_sel = i_wdata[3:0];
        end
        if (i_wr && i_addr == A_REF_HI) begin
            st_nxt.ro_div = i_wdata[14:0];
        end
        // generator: a stopping clock finishes its high phase first
        if (st_r.div_eff == 15'h0000) begin
            st_nxt.cnt = 15'h0000;
            if (run || st_r.ro_clk) begin
                st_nxt.ro_clk = src_bit; // R24
            end
        end else if (!run && !st_r.ro_clk) begin
            st_nxt.cnt = 15'h0000; // R26
        end else if (src_bit && !st_r.src_prev) begin
            if (st_r.cnt + 15'h0001 >= st_r.div_eff) begin
                tgl = 1'b1;
                st_nxt.ro_clk = !st_r.ro_clk; // R2 R24
                st_nxt.cnt = 15'h0000;
            end else begin
                st_nxt.cnt = st_r.cnt + 15'h0001;
            end
        end
        // new divider lands on an edge or while parked low, so no short
        // half period escapes and a fresh start never uses the old one
        if (st_r.ro_swreq && (tgl || st_r.div_eff == 15'h0000
            || !st_r.ro_act || (!run && !st_r.ro_clk))) begin
            st_nxt.div_eff = st_r.ro_div; // R3
            st_nxt.cnt = 15'h0000;
            st_nxt.ro_swreq = 1'b0; // R3
        end
        st_nxt.ro_act = run || st_nxt.ro_clk; // R7
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
            st_r.clock_divider_control <= CLOCK_DIVIDER_CONTROL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_switch_req = st_r.sw_req;
    assign o_requested_clock_source = st_r.req_src;
    assign o_current_clock_source = st_r.cur_src;
    assign o_primary_osc_run = !i_sleep || st_r.primary_osc_keep; // R17
    assign o_secondary_osc_enable = st_r.secondary_osc_en;
    // pll left free for the reference clock takes its input from straps
    assign o_pll_input_frc = pll_mode ? st_r.cur_src == SRC_FRC_PLL
        : !i_pll_source_select_config; // R9
    assign o_pin_map_frozen = st_r.pin_frz;
    assign o_selftune_run = st_r.st_en && !(i_idle && st_r.st_idl)
        && !oor; // R20 R22
    assign o_selftune_ref_select = st_r.st_src;
    assign o_selftune_in_range_event = in_rng ^ (st_r.st_en
        && st_r.st_lpol); // R21
    assign o_selftune_out_of_range_event = oor ^ (st_r.st_en
        && st_r.st_orpol); // R22
    assign o_frc_trim = st_r.trim;
    assign o_clock_divider_control_cfg = st_r.clock_divider_control;
    assign o_system_osc_divisor_cfg = st_r.system_osc_divisor;
    assign o_system_osc_fractional_divisor_cfg = st_r.system_osc_fractional_divisor;
    assign o_refclk = st_r.ro_clk;
    assign o_reference_clock_pin = st_r.ro_clk & st_r.ro_out; // R6
    assign o_reference_clock_pin_oe_n = !st_r.ro_out; // R6

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    property p_off_low;
        !st_r.ro_en && !o_refclk ##1 !st_r.ro_en |-> !o_refclk;
    endproperty
    a_off_low: assert property (p_off_low) // R26
        else $error("reference clock moved while disabled");

    property p_act_clear;
        !run && !o_refclk |=> !st_r.ro_act;
    endproperty
    a_act_clear: assert property (p_act_clear) // R7
        else $error("active status stuck after disable");

    property p_act_on;
        run |=> st_r.ro_act;
    endproperty
    a_act_on: assert property (p_act_on) // R1
        else $error("enabled module not active");

    property p_div_step;
        $changed(o_refclk) && $past(st_r.div_eff) != 15'h0000
            |-> $past(st_r.cnt) + 15'h0001 >= $past(st_r.div_eff);
    endproperty
    a_div_step: assert property (p_div_step) // R2
        else $error("divided output toggled early");

    property p_div_load;
        st_r.ro_swreq && !st_r.ro_act
            |=> !st_r.ro_swreq && st_r.div_eff == $past(st_r.ro_div);
    endproperty
    a_div_load: assert property (p_div_load) // R3
        else $error("divider switch not completed");

    property p_wlock;
        i_wr && i_addr == A_OSC_CTRL && st_r.key_st != KEY_OPEN
            && st_r.started |=> $stable(st_r.req_src);
    endproperty
    a_wlock: assert property (p_wlock) // R10
        else $error("locked control register changed");

    property p_freeze;
        sel_frozen && st_r.started |=> $stable(st_r.req_src);
    endproperty
    a_freeze: assert property (p_freeze) // R13
        else $error("frozen selection changed");

    property p_switch;
        st_r.sw_req && i_switch_done && st_r.started
            |=> !st_r.sw_req && st_r.cur_src == $past(st_r.req_src);
    endproperty
    a_switch: assert property (p_switch) // R12
        else $error("switch did not complete");

    property p_pin_once;
        st_r.pin_frz && i_pin_map_freeze_once_config |=> st_r.pin_frz;
    endproperty
    a_pin_once: assert property (p_pin_once) // R14
        else $error("one-way pin freeze cleared");

    property p_fail;
        i_clock_fail |=> st_r.cf;
    endproperty
    a_fail: assert property (p_fail) // R16
        else $error("clock failure not flagged");

    property p_pll_ok;
        !pll_mode || st_r.sw_req |=> !st_r.pll_ok;
    endproperty
    a_pll_ok: assert property (p_pll_ok) // R15
        else $error("pll settled in non-pll mode");

    property p_trim;
        st_r.st_en |=> st_r.trim == $past(i_selftune_trim);
    endproperty
    a_trim: assert property (p_trim) // R19
        else $error("trim not owned by self-tune");
endmodule
`default_nettype wire

// ===== dv/oscillator_refclk_control_bench.sv
`default_nettype none
module oscillator_refclk_control_bench
    import osc_refclk_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [11:0] i_addr = 12'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_ref_src = 8'h00;
    logic i_pll_locked = 1'b1;
    logic [2:0] i_reset_clock_source = 3'h0;
    logic [1:0] i_fail_safe_monitor_config = 2'h0;
    logic i_pin_map_freeze_once_config = 1'b1;
    logic i_pll_source_select_config = 1'b0;
    logic i_switch_done = 1'b0;
    logic i_clock_fail = 1'b0;
    logic i_sleep = 1'b0;
    logic i_idle = 1'b0;
    logic i_selftune_in_range = 1'b0;
    logic i_selftune_out_of_range = 1'b0;
    logic [5:0] i_selftune_trim = 6'h00;
    logic [15:0] o_rdata, o_clock_divider_control_cfg, o_system_osc_divisor_cfg, o_system_osc_fractional_divisor_cfg;
    logic [2:0] o_requested_clock_source, o_current_clock_source;
    logic [5:0] o_frc_trim;
    logic o_switch_req, o_primary_osc_run, o_secondary_osc_enable;
    logic o_pll_input_frc, o_pin_map_frozen, o_selftune_run;
    logic o_selftune_ref_select, o_selftune_in_range_event;
    logic o_selftune_out_of_range_event, o_refclk;
    logic o_reference_clock_pin, o_reference_clock_pin_oe_n;
    int err_total = 0;
    int total_checks = 0;
    int ref_rises = 0;
    int pin_rises = 0;
    logic ref_q = 1'b0;
    logic pin_q = 1'b0;
    logic [1:0] sc = 2'h0;
    logic [7:0] smask = 8'h00;
    logic [15:0] d;

    osc_refclk_ctrl osc_refclk_ctrl_inst (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ref_src(i_ref_src), .i_pll_locked(i_pll_locked),
        .i_reset_clock_source(i_reset_clock_source),
        .i_fail_safe_monitor_config(i_fail_safe_monitor_config),
        .i_pin_map_freeze_once_config(i_pin_map_freeze_once_config),
        .i_pll_source_select_config(i_pll_source_select_config),
        .i_switch_done(i_switch_done), .i_clock_fail(i_clock_fail),
        .i_sleep(i_sleep), .i_idle(i_idle),
        .i_selftune_in_range(i_selftune_in_range),
        .i_selftune_out_of_range(i_selftune_out_of_range),
        .i_selftune_trim(i_selftune_trim), .o_switch_req(o_switch_req),
        .o_requested_clock_source(o_requested_clock_source),
        .o_current_clock_source(o_current_clock_source),
        .o_primary_osc_run(o_primary_osc_run),
        .o_secondary_osc_enable(o_secondary_osc_enable),
        .o_pll_input_frc(o_pll_input_frc),
        .o_pin_map_frozen(o_pin_map_frozen),
        .o_selftune_run(o_selftune_run),
        .o_selftune_ref_select(o_selftune_ref_select),
        .o_selftune_in_range_event(o_selftune_in_range_event),
        .o_selftune_out_of_range_event(o_selftune_out_of_range_event),
        .o_frc_trim(o_frc_trim), .o_clock_divider_control_cfg(o_clock_divider_control_cfg),
        .o_system_osc_divisor_cfg(o_system_osc_divisor_cfg), .o_system_osc_fractional_divisor_cfg(o_system_osc_fractional_divisor_cfg),
        .o_refclk(o_refclk), .o_reference_clock_pin(o_reference_clock_pin),
        .o_reference_clock_pin_oe_n(o_reference_clock_pin_oe_n)
    );

    always #50 i_core_clk = ~i_core_clk;

    // all enabled sources share one 4-cycle waveform, smask picks who runs
    always @(posedge i_core_clk) begin
        sc <= sc + 2'h1;
        i_ref_src <= sc[1] ? smask : 8'h00;
        ref_q <= o_refclk;
        pin_q <= o_reference_clock_pin;
        if (o_refclk === 1'b1 && ref_q !== 1'b1) ref_rises++;
        if (o_reference_clock_pin === 1'b1 && pin_q !== 1'b1) pin_rises++;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, seen, exp);
        end
    endtask

    function automatic logic [15:0] inr(int v, int lo, int hi);
        return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
    endfunction

    task automatic ticks(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    // every bus task is entered just after a rising edge
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [15:0] v);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(negedge i_core_clk);
        v = o_rdata;
        @(posedge i_core_clk);
    endtask

    task automatic osc_wr(input logic [15:0] v);
        wr(A_UNLOCK, UNLOCK_KEY1);
        wr(A_UNLOCK, UNLOCK_KEY2);
        wr(A_OSC_CTRL, v);
    endtask

    task automatic done_pulse();
        i_switch_done <= 1'b1;
        @(posedge i_core_clk);
        i_switch_done <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic t_reset();
        logic [11:0] adr [5];
        logic [15:0] exp [5];
        adr = '{A_CLOCK_DIVIDER_CONTROL, A_FRC_TUNE, A_REF_LO, A_REF_HI, 12'hffc};
        exp = '{CLOCK_DIVIDER_CONTROL_RST, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        foreach (adr[k]) begin
            rd(adr[k], d);
            check(d, exp[k], "reset value");
        end
        check(o_reference_clock_pin_oe_n, 16'h1, "pin idle");
        check(o_refclk, 16'h0, "refclk idle");
        check(o_current_clock_source, 16'h0, "strap source");
        check(o_pll_input_frc, 16'h1, "pll from fast rc");
    endtask

    task automatic t_switch();
        wr(A_OSC_CTRL, 16'h0201);
        check(o_switch_req, 16'h0, "locked write");
        osc_wr(16'h0201);
        check(o_switch_req, 16'h1, "switch start");
        check(o_requested_clock_source, 16'h2, "req src");
        done_pulse();
        check(o_switch_req, 16'h0, "switch end");
        check(o_current_clock_source, 16'h2, "cur src");
        rd(A_OSC_CTRL, d);
        check(d[14:12], 16'h2, "cur field");
        check(d[0], 16'h0, "req bit clear");
        check(d[5], 16'h0, "pll ok non-pll");
        osc_wr(16'h0101);
        done_pulse();
        ticks(4);
        rd(A_OSC_CTRL, d);
        check(d[5], 16'h1, "pll ok");
        osc_wr(16'h0181);
        done_pulse();
        osc_wr(16'h0501);
        check(o_switch_req, 16'h0, "frozen req");
        check(o_requested_clock_source, 16'h1, "frozen src");
        i_fail_safe_monitor_config <= 2'h2;
        i_sleep <= 1'b1;
        osc_wr(16'h0507);
        check(o_switch_req, 16'h1, "monitor off");
        check(o_secondary_osc_enable, 16'h1, "secondary_osc on");
        check(o_primary_osc_run, 16'h1, "primary_osc keep");
        done_pulse();
        check(o_current_clock_source, 16'h5, "cur low_power_rc_osc");
        i_pll_source_select_config <= 1'b1;
        osc_wr(16'h0540);
        check(o_pll_input_frc, 16'h0, "pll from primary");
        check(o_secondary_osc_enable, 16'h0, "secondary_osc off");
        check(o_primary_osc_run, 16'h0, "primary_osc sleep off");
        check(o_pin_map_frozen, 16'h1, "pin freeze");
        i_sleep <= 1'b0;
        osc_wr(16'h0500);
        check(o_pin_map_frozen, 16'h1, "freeze once");
        i_clock_fail <= 1'b1;
        @(posedge i_core_clk);
        i_clock_fail <= 1'b0;
        @(posedge i_core_clk);
        rd(A_OSC_CTRL, d);
        check(d[3], 16'h1, "clock fail");
    endtask

    task automatic run_ref(input logic [15:0] hi, input logic [15:0] lo,
                           input logic [7:0] m, output int r, output int p,
                           output logic a);
        int r0;
        int p0;
        smask <= m;
        wr(A_REF_HI, hi);
        wr(A_REF_LO, lo);
        ticks(40);
        rd(A_REF_LO, d);
        a = d[8];
        check(d[9], 16'h0, "div switch done");
        r0 = ref_rises;
        p0 = pin_rises;
        ticks(320);
        r = ref_rises - r0;
        p = pin_rises - p0;
        wr(A_REF_LO, lo & 16'h7dff);
        // settings stay untouched until the block reports idle
        for (int k = 0; k < 20 && d[8] !== 1'b0; k++) rd(A_REF_LO, d);
        check(d[8], 16'h0, "inactive");
        r0 = ref_rises;
        ticks(40);
        check(o_refclk, 16'h0, "off low");
        check(16'(ref_rises - r0), 16'h0, "off quiet");
    endtask

    task automatic t_ref();
        int r;
        int p;
        logic a;
        logic [3:0] codes [8];
        logic [7:0] m;
        codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
        run_ref(16'h0002, 16'h9203, 8'h08, r, p, a);
        check(inr(r, 19, 21), 16'h1, "div 2");
        check(16'(p), 16'(r), "pin follows");
        check(a, 16'h1, "active");
        check(o_reference_clock_pin_oe_n, 16'h0, "pin drive kept");
        run_ref(16'h0000, 16'h8203, 8'h08, r, p, a);
        check(inr(r, 79, 81), 16'h1, "bypass");
        check(16'(p), 16'h0, "pin off");
        foreach (codes[k]) begin
            m = (codes[k] == 4'h8) ? 8'h80 : (8'h01 << codes[k]);
            run_ref(16'h0001, {12'h920, codes[k]}, m, r, p, a);
            check(inr(r, 39, 41), 16'h1, "source sel");
            run_ref(16'h0001, {12'h920, codes[k]}, ~m, r, p, a);
            check(16'(r), 16'h0, "other source");
        end
        run_ref(16'h0001, 16'h9207, 8'hff, r, p, a);
        check(16'(r), 16'h0, "reserved code");
        i_sleep <= 1'b1;
        run_ref(16'h0001, 16'h9203, 8'h08, r, p, a);
        check(16'(r), 16'h0, "sleep stop");
        run_ref(16'h0001, 16'h9a03, 8'h08, r, p, a);
        check(inr(r, 39, 41), 16'h1, "sleep run");
        i_sleep <= 1'b0;
    endtask

    task automatic t_tune();
        wr(A_FRC_TUNE, 16'h0020);
        rd(A_FRC_TUNE, d);
        check(d, 16'h0020, "sw trim");
        check(o_frc_trim, 16'h20, "trim out");
        i_selftune_trim <= 6'h1f;
        i_selftune_in_range <= 1'b1;
        i_selftune_out_of_range <= 1'b1;
        wr(A_FRC_TUNE, 16'h9405);
        ticks(2);
        check(o_frc_trim, 16'h1f, "hw trim");
        check(o_selftune_ref_select, 16'h1, "ref sel");
        check(o_selftune_run, 16'h0, "tune halted out of range");
        check(o_selftune_in_range_event, 16'h0, "lock pol 1");
        check(o_selftune_out_of_range_event, 16'h1, "or pol 0");
        rd(A_FRC_TUNE, d);
        check({d[11], d[9]}, 16'h3, "status");
        i_idle <= 1'b1;
        i_selftune_out_of_range <= 1'b0;
        wr(A_FRC_TUNE, 16'ha100);
        check(o_selftune_run, 16'h0, "idle stop");
        check(o_selftune_ref_select, 16'h0, "ref secondary_osc");
        check(o_selftune_in_range_event, 16'h1, "lock pol 0");
        check(o_selftune_out_of_range_event, 16'h1, "or pol 1");
        i_idle <= 1'b0;
        @(posedge i_core_clk);
        check(o_selftune_run, 16'h1, "tune run");
        wr(A_FRC_TUNE, 16'h0000);
    endtask

    task automatic t_div();
        wr(A_SYSTEM_OSC_DIVISOR, 16'hffff);
        wr(A_SYSTEM_OSC_FRACTIONAL_DIVISOR, 16'hffff);
        wr(A_CLOCK_DIVIDER_CONTROL, 16'hffff);
        check(o_system_osc_divisor_cfg, SYSTEM_OSC_DIVISOR_MASK, "divisor");
        check(o_system_osc_fractional_divisor_cfg, SYSTEM_OSC_FRACTIONAL_DIVISOR_MASK, "fraction");
        check(o_clock_divider_control_cfg, CLOCK_DIVIDER_CONTROL_MASK, "clock divider");
        rd(A_SYSTEM_OSC_FRACTIONAL_DIVISOR, d);
        check(d, SYSTEM_OSC_FRACTIONAL_DIVISOR_MASK, "fraction read");
    endtask

    initial begin
        #(100 * 40000);
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        ticks(2);
        t_reset();
        t_switch();
        t_ref();
        t_tune();
        t_div();
        report_and_stop();
    end
endmodule
`default_nettype wire
